// file: dd_dma.sv
// Purpose: Source/destination DMA channel pair with register and descriptor flows.
// Assumes: Memory ports answer with a one-cycle ack; counts are at least one.
// Notes:   A peripheral is reached as a fixed address with a zero step.
`timescale 1ns/1ns
`default_nettype none
`include "dd_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
module dd_fifo #(
    parameter int W = 32,
    parameter int D = 32
) (
    // Clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rst,
    // Fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // Drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0]  mem_r [D];
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0]   cnt_r, cnt_nxt;
    logic          push, pop;

    assign in_ready  = (cnt_r != (AW+1)'(D));
    assign out_valid = (cnt_r != '0);
    assign out_data  = mem_r[rp_r];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        wp_nxt  = push ? AW'(wp_r + 1'b1) : wp_r;
        rp_nxt  = pop ? AW'(rp_r + 1'b1) : rp_r;
        cnt_nxt = (AW+1)'(cnt_r + push - pop);
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
        if (push) begin
            mem_r[wp_r] <= in_data;
        end
    end
endmodule // dd_fifo

////////////////////////////////////////////////////////////////////////////////
module dd_dma import dd_pkg::*; (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // Channel setup and control
    input  wire dd_cfg_t     cfg,
    input  wire logic        start,
    input  wire logic        trig_in,
    input  wire logic        halt,
    // Source memory port
    output var dd_rd_req_t   rd,
    input  wire logic        rd_ack,
    input  wire logic [31:0] rd_data,
    // Destination memory port
    output var dd_wr_req_t   wr,
    input  wire logic        wr_ack,
    // Events
    output logic             busy,
    output logic             buf_irq,
    output logic             frac_irq,
    output logic             done_trig
);
    dd_state_t   st_r, st_nxt;
    dd_cfg_t     cfg_r, cfg_nxt;
    dd_rd_req_t  rd_r, rd_nxt;
    dd_wr_req_t  wr_r, wr_nxt;
    logic [2:0]  di_r, di_nxt, words;
    logic [31:0] base_r, base_nxt, addr_r, addr_nxt, np_r, np_nxt;
    logic [31:0] xs_r, xs_nxt, ys_r, ys_nxt, dptr_r, dptr_nxt;
    logic [31:0] step_r, step_nxt, fc_r, fc_nxt, tot;
    logic [15:0] xc_r, xc_nxt, yc_r, yc_nxt, xi_r, xi_nxt, yi_r, yi_nxt;
    logic        chain_r, chain_nxt, halt_r, halt_nxt, busy_r, busy_nxt;
    logic        bi_r, bi_nxt, fi_r, fi_nxt, dt_r, dt_nxt, go;
    logic        push, pop, f_ready, f_valid, dst_load;
    logic [31:0] f_data, dst_src;

    assign rd        = rd_r;
    assign wr        = wr_r;
    assign busy      = busy_r;
    assign buf_irq   = bi_r;
    assign frac_irq  = fi_r;
    assign done_trig = dt_r;

    // Source pushes, destination pops: the two sides of one stream
    dd_fifo #(.W(`DD_FIFO_W), .D(`DD_FIFO_D)) u_fifo (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .in_valid  (push),
        .in_ready  (f_ready),
        .in_data   (rd_data),
        .out_valid (f_valid),
        .out_ready (pop),
        .out_data  (f_data)
    );

    always_comb begin
        case (cfg_r.flow)
            FL_PP:   words = `DD_W_PP;
            FL_LIN:  words = `DD_W_LIN;
            FL_ARR:  words = `DD_W_ARR;
            default: words = `DD_W_2D;
        endcase
        go = !halt_r && (cfg_r.flow == FL_AUTO || cfg_r.flow == FL_PP ||
             cfg_r.flow == FL_ARR || (cfg_r.flow != FL_STOP && chain_r));
        tot = 32'(xc_r) * 32'(yc_r);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Source side and sequencing
    always_comb begin
        st_nxt    = st_r;
        cfg_nxt   = cfg_r;
        rd_nxt    = rd_r;
        di_nxt    = di_r;
        base_nxt  = base_r;
        addr_nxt  = addr_r;
        np_nxt    = np_r;
        xs_nxt    = xs_r;
        ys_nxt    = ys_r;
        xc_nxt    = xc_r;
        yc_nxt    = yc_r;
        xi_nxt    = xi_r;
        yi_nxt    = yi_r;
        step_nxt  = step_r;
        fc_nxt    = fc_r;
        chain_nxt = chain_r;
        halt_nxt  = halt_r | halt;
        busy_nxt  = busy_r;
        bi_nxt    = 1'b0;
        fi_nxt    = 1'b0;
        dt_nxt    = 1'b0;
        push      = 1'b0;
        dst_load  = 1'b0;
        dst_src   = cfg_r.dst;
        case (st_r)
            S_IDLE: begin
                if (start || trig_in) begin
                    cfg_nxt   = cfg;
                    halt_nxt  = 1'b0;
                    busy_nxt  = 1'b1;
                    chain_nxt = 1'b0;
                    base_nxt  = cfg.src;
                    xs_nxt    = cfg.xs;
                    ys_nxt    = cfg.ys;
                    xc_nxt    = cfg.xc;
                    yc_nxt    = cfg.yc;
                    dst_load  = 1'b1;
                    dst_src   = cfg.dst;
                    di_nxt    = 3'h0;
                    rd_nxt.addr = cfg.desc;
                    if (cfg.flow == FL_STOP || cfg.flow == FL_AUTO) begin
                        st_nxt = S_LOAD;
                    end else begin
                        st_nxt = S_FETCH;
                    end
                end
            end
            S_FETCH: begin
                if (!rd_r.req) begin
                    rd_nxt.req = 1'b1;
                end else if (rd_ack) begin
                    rd_nxt.req  = 1'b0;
                    rd_nxt.addr = rd_r.addr + `DD_WORD_STEP;
                    di_nxt      = 3'(di_r + 3'h1);
                    case (cfg_r.flow)
                        FL_PP: begin
                            if (di_r == 3'h0) np_nxt = rd_data;
                            else base_nxt = rd_data;
                        end
                        FL_LIN: begin
                            case (di_r)
                                3'h0: np_nxt = rd_data;
                                3'h1: base_nxt = rd_data;
                                3'h2: begin
                                    xc_nxt = rd_data[15:0];
                                    yc_nxt = 16'h1;
                                end
                                default: chain_nxt = rd_data[`DD_CHAIN_BIT];
                            endcase
                        end
                        FL_ARR: begin
                            base_nxt = rd_data;
                            np_nxt   = rd_r.addr + `DD_WORD_STEP;
                        end
                        default: begin
                            case (di_r)
                                3'h0: np_nxt = rd_data;
                                3'h1: base_nxt = rd_data;
                                3'h2: begin
                                    xc_nxt = rd_data[15:0];
                                    yc_nxt = rd_data[31:16];
                                end
                                3'h3: xs_nxt = rd_data;
                                3'h4: ys_nxt = rd_data;
                                default: chain_nxt = rd_data[`DD_CHAIN_BIT];
                            endcase
                        end
                    endcase
                    if (di_r == 3'(words - 3'h1)) begin
                        st_nxt = S_LOAD;
                    end
                end
            end
            S_LOAD: begin
                addr_nxt = base_r;
                xi_nxt   = xc_r;
                yi_nxt   = yc_r;
                if (cfg_r.frac == `DD_FRAC_NONE) step_nxt = 32'h0;
                else if (cfg_r.frac == `DD_FRAC_HALF) step_nxt = tot >> 1;
                else step_nxt = tot >> 2;
                fc_nxt   = step_nxt;
                st_nxt   = S_READ;
            end
            S_READ: begin
                // One read in flight and issued only with room, so every ack fits
                if (!rd_r.req) begin
                    if (f_ready) begin
                        rd_nxt.req  = 1'b1;
                        rd_nxt.addr = addr_r;
                    end
                end else if (rd_ack) begin
                    rd_nxt.req = 1'b0;
                    push       = 1'b1;
                    if (step_r != 32'h0) begin
                        if (fc_r == 32'h1) begin
                            fi_nxt = 1'b1;
                            fc_nxt = step_r;
                        end else begin
                            fc_nxt = fc_r - 32'h1;
                        end
                    end
                    if (xi_r == 16'h1) begin
                        if (yi_r == 16'h1) begin
                            st_nxt = S_DRAIN;
                        end else begin
                            addr_nxt = addr_r + ys_r;
                            xi_nxt   = xc_r;
                            yi_nxt   = yi_r - 16'h1;
                        end
                    end else begin
                        addr_nxt = addr_r + xs_r;
                        xi_nxt   = xi_r - 16'h1;
                    end
                end
            end
            S_DRAIN: begin
                if (!f_valid && !wr_r.req) begin
                    st_nxt = S_DONE;
                end
            end
            S_DONE: begin
                bi_nxt = 1'b1;
                if (!go) begin
                    st_nxt   = S_IDLE;
                    busy_nxt = 1'b0;
                    dt_nxt   = 1'b1;
                end else if (cfg_r.flow == FL_AUTO) begin
                    base_nxt = cfg_r.src;
                    xs_nxt   = cfg_r.xs;
                    ys_nxt   = cfg_r.ys;
                    xc_nxt   = cfg_r.xc;
                    yc_nxt   = cfg_r.yc;
                    dst_load = 1'b1;
                    st_nxt   = S_LOAD;
                end else begin
                    rd_nxt.addr = np_r;
                    di_nxt      = 3'h0;
                    st_nxt      = S_FETCH;
                end
            end
            default: st_nxt = S_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Destination side
    always_comb begin
        wr_nxt   = wr_r;
        dptr_nxt = dst_load ? dst_src : dptr_r;
        pop      = 1'b0;
        if (!wr_r.req) begin
            if (f_valid) begin
                pop         = 1'b1;
                wr_nxt.req  = 1'b1;
                wr_nxt.addr = dptr_r;
                wr_nxt.data = f_data;
            end
        end else if (wr_ack) begin
            wr_nxt.req = 1'b0;
            dptr_nxt   = dptr_r + cfg_r.ds;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_r    <= S_IDLE;
            cfg_r   <= '0;
            rd_r    <= '0;
            wr_r    <= '0;
            di_r    <= 3'h0;
            base_r  <= `DD_ADDR_RST;
            addr_r  <= `DD_ADDR_RST;
            np_r    <= `DD_ADDR_RST;
            dptr_r  <= `DD_ADDR_RST;
            xs_r    <= 32'h0;
            ys_r    <= 32'h0;
            xc_r    <= 16'h0;
            yc_r    <= 16'h0;
            xi_r    <= 16'h0;
            yi_r    <= 16'h0;
            step_r  <= 32'h0;
            fc_r    <= 32'h0;
            chain_r <= 1'b0;
            halt_r  <= 1'b0;
            busy_r  <= 1'b0;
            bi_r    <= 1'b0;
            fi_r    <= 1'b0;
            dt_r    <= 1'b0;
        end else begin
            st_r    <= st_nxt;
            cfg_r   <= cfg_nxt;
            rd_r    <= rd_nxt;
            wr_r    <= wr_nxt;
            di_r    <= di_nxt;
            base_r  <= base_nxt;
            addr_r  <= addr_nxt;
            np_r    <= np_nxt;
            dptr_r  <= dptr_nxt;
            xs_r    <= xs_nxt;
            ys_r    <= ys_nxt;
            xc_r    <= xc_nxt;
            yc_r    <= yc_nxt;
            xi_r    <= xi_nxt;
            yi_r    <= yi_nxt;
            step_r  <= step_nxt;
            fc_r    <= fc_nxt;
            chain_r <= chain_nxt;
            halt_r  <= halt_nxt;
            busy_r  <= busy_nxt;
            bi_r    <= bi_nxt;
            fi_r    <= fi_nxt;
            dt_r    <= dt_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    property p_reg_start;
        st_r == S_IDLE && (start || trig_in) && (cfg.flow == FL_STOP) |=> st_r == S_LOAD
            ##1 st_r == S_READ ##1 rd_r.req && rd_r.addr == $past(base_r, 2);
    endproperty
    a_reg_start: assert property (p_reg_start) else $error("register start slow");
    property p_desc_start;
        st_r == S_IDLE && start && cfg.flow == FL_LIN |=> st_r == S_FETCH
            && rd_r.addr == $past(cfg.desc) ##1 rd_r.req;
    endproperty
    a_desc_start: assert property (p_desc_start) else $error("no descriptor fetch");
    property p_desc_step;
        st_r == S_FETCH && rd_r.req && rd_ack |=> rd_r.addr == $past(rd_r.addr) + 32'h4;
    endproperty
    a_desc_step: assert property (p_desc_step) else $error("descriptor not consecutive");
    property p_elem_step;
        st_r == S_READ && rd_r.req && rd_ack && xi_r != 16'h1
            |=> addr_r == $past(addr_r) + $past(xs_r);
    endproperty
    a_elem_step: assert property (p_elem_step) else $error("wrong element step");
    property p_row_step;
        st_r == S_READ && rd_r.req && rd_ack && xi_r == 16'h1 && yi_r != 16'h1
            |=> addr_r == $past(addr_r) + $past(ys_r);
    endproperty
    a_row_step: assert property (p_row_step) else $error("wrong row step");
    property p_stop;
        st_r == S_DONE && cfg_r.flow == FL_STOP |=> st_r == S_IDLE && !busy_r
            && dt_r ##1 !dt_r && st_r == S_IDLE;
    endproperty
    a_stop: assert property (p_stop) else $error("linear buffer did not stop");
    property p_reload;
        st_r == S_DONE && cfg_r.flow == FL_AUTO && !halt_r
            |=> st_r == S_LOAD && base_r == cfg_r.src && dptr_r == cfg_r.dst;
    endproperty
    a_reload: assert property (p_reload) else $error("auto-reload lost setup");
    property p_full_irq;
        st_r == S_DRAIN && !f_valid && !wr_r.req |=> ##1 bi_r;
    endproperty
    a_full_irq: assert property (p_full_irq) else $error("no buffer interrupt");
    property p_busy;
        st_r != S_IDLE && st_r != S_DONE |=> busy_r;
    endproperty
    a_busy: assert property (p_busy) else $error("channel dropped work");
    property p_wr_src;
        $rose(wr_r.req) |-> $past(f_valid) && wr_r.addr == $past(dptr_r);
    endproperty
    a_wr_src: assert property (p_wr_src) else $error("write without data");
    property p_frac;
        fi_r |-> $past(step_r) != 32'h0 && $past(fc_r) == 32'h1;
    endproperty
    a_frac: assert property (p_frac) else $error("stray fraction interrupt");

    c_stop: cover property (st_r == S_DONE && cfg_r.flow == FL_STOP);
    c_wrap: cover property (st_r == S_DONE && cfg_r.flow == FL_AUTO ##[1:20] fi_r);
    c_chain: cover property (st_r == S_DONE && cfg_r.flow == FL_LIN && go);
    c_full: cover property (!f_ready);
endmodule // dd_dma
`default_nettype wire

// file: dd_cfg.svh
// Purpose: Constants of the descriptor DMA controller.
// Assumes: 32-bit words, byte addresses, one request in flight per port.
// Notes:   Descriptor layouts are given as word counts and field positions.
`ifndef DD_CFG_SVH
`define DD_CFG_SVH
`define DD_FIFO_W     32
`define DD_FIFO_D     32
`define DD_WORD_STEP  32'h4
`define DD_W_PP       3'h2
`define DD_W_LIN      3'h4
`define DD_W_ARR      3'h1
`define DD_W_2D       3'h6
`define DD_CHAIN_BIT  0
`define DD_FRAC_NONE  2'h0
`define DD_FRAC_HALF  2'h1
`define DD_ADDR_RST   32'h0
`endif

// file: dd_pkg.sv
// Purpose: Types of the descriptor DMA controller.
// Assumes: Constants come from dd_cfg.svh.
// Notes:   Flow codes select register or descriptor operation.
`default_nettype none
package dd_pkg;
    typedef enum logic [2:0] {
        FL_STOP = 3'h0, FL_AUTO = 3'h1, FL_PP = 3'h2,
        FL_LIN  = 3'h3, FL_ARR  = 3'h4, FL_2D = 3'h5
    } dd_flow_t;
    typedef enum logic [5:0] {
        S_IDLE = 6'h01, S_FETCH = 6'h02, S_LOAD = 6'h04,
        S_READ = 6'h08, S_DRAIN = 6'h10, S_DONE = 6'h20
    } dd_state_t;
    typedef struct packed {
        dd_flow_t           flow;
        logic [1:0]         frac;
        logic [31:0]        src;
        logic [31:0]        dst;
        logic [31:0]        desc;
        logic signed [31:0] xs;
        logic signed [31:0] ys;
        logic signed [31:0] ds;
        logic [15:0]        xc;
        logic [15:0]        yc;
    } dd_cfg_t;
    typedef struct packed {
        logic        req;
        logic [31:0] addr;
    } dd_rd_req_t;
    typedef struct packed {
        logic        req;
        logic [31:0] addr;
        logic [31:0] data;
    } dd_wr_req_t;
endpackage
`default_nettype wire

// file: dd_mem_model.sv
// Purpose: Memory on the far side of the DMA read and write ports.
// Assumes: 256 words indexed by address bits 9:2; acks are registered pulses.
// Notes:   Idle read data flips every cycle, so a stale word never passes for data.
`timescale 1ns/1ns
`default_nettype none
module dd_mem_model import dd_pkg::*; (
    // Clock
    input  wire logic       sys_clk,
    // Read port
    input  wire dd_rd_req_t rd,
    output logic            rd_ack,
    output logic [31:0]     rd_data,
    // Write port
    input  wire dd_wr_req_t wr,
    output logic            wr_ack
);
    logic [31:0] mem [256];
    logic [31:0] rlog [$];
    logic [31:0] wlog_a [$];
    logic [31:0] wlog_d [$];
    int          lat = 0;
    int          rcnt = 0;
    int          wcnt = 0;

    initial begin
        rd_ack  = 1'b0;
        wr_ack  = 1'b0;
        rd_data = 32'h0;
    end

    // Wait states set by lat; the ack cycle itself is skipped so one request gives one ack
    always @(posedge sys_clk) begin
        rd_ack  <= 1'b0;
        wr_ack  <= 1'b0;
        rd_data <= ~rd_data;
        if (rd.req && !rd_ack) begin
            rcnt <= (rcnt >= lat) ? 0 : rcnt + 1;
            if (rcnt >= lat) begin
                rd_ack  <= 1'b1;
                rd_data <= mem[rd.addr[9:2]];
                rlog.push_back(rd.addr);
            end
        end
        if (wr.req && !wr_ack) begin
            wcnt <= (wcnt >= lat) ? 0 : wcnt + 1;
            if (wcnt >= lat) begin
                wr_ack <= 1'b1;
                mem[wr.addr[9:2]] <= wr.data;
                wlog_a.push_back(wr.addr);
                wlog_d.push_back(wr.data);
            end
        end
    end
endmodule // dd_mem_model
`default_nettype wire

// file: tb_descriptor_dma_controller.sv
// Purpose: Self-checking bench for the DMA channel pair.
// Assumes: Sources below 0x100, destinations at 0x200, descriptors at 0x300.
// Notes:   Expected data comes from the preload pattern, never from the design.
`timescale 1ns/1ns
`default_nettype none
module tb_descriptor_dma_controller import dd_pkg::*; ();
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    dd_cfg_t     cfg = '0;
    logic        start = 1'b0;
    logic        trig_in = 1'b0;
    logic        halt = 1'b0;
    dd_rd_req_t  rd;
    logic        rd_ack;
    logic [31:0] rd_data;
    dd_wr_req_t  wr;
    logic        wr_ack;
    logic        busy;
    logic        buf_irq;
    logic        frac_irq;
    logic        done_trig;
    int          bad_count = 0;
    int          check_count = 0;
    int          nb;
    int          nf;
    int          cyc = 0;
    logic [31:0] er [$];

    dd_dma DUT (.sys_clk(sys_clk), .rst(rst), .cfg(cfg), .start(start), .trig_in(trig_in),
        .halt(halt), .rd(rd), .rd_ack(rd_ack), .rd_data(rd_data), .wr(wr), .wr_ack(wr_ack),
        .busy(busy), .buf_irq(buf_irq), .frac_irq(frac_irq), .done_trig(done_trig));
    dd_mem_model mem_i (.sys_clk(sys_clk), .rd(rd), .rd_ack(rd_ack), .rd_data(rd_data),
        .wr(wr), .wr_ack(wr_ack));

    initial begin
        forever #50 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] pat(input logic [31:0] a);
        return 32'h5a5a0000 + 32'(a[9:2]);
    endfunction

    function automatic dd_cfg_t mk(input dd_flow_t f, input logic [1:0] fr,
        input logic [31:0] s, x, d, dsv, dsc, input logic [15:0] n);
        return '{flow: f, frac: fr, src: s, dst: d, desc: dsc, xs: x, ys: 32'sh4,
                 ds: dsv, xc: n, yc: 16'h1};
    endfunction

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_q(input string what, input logic [31:0] e [$], input logic [31:0] g [$]);
        chk({what, " count"}, 32'h1, 32'(g.size() >= e.size()));
        for (int i = 0; i < e.size() && i < g.size(); i++) chk(what, e[i], g[i]);
    endtask

    // Preloads consecutive memory words from a list
    task automatic put(input int at, input logic [31:0] w [$]);
        foreach (w[i]) mem_i.mem[at + i] = w[i];
    endtask

    task automatic chk_wr(input int n, input logic [31:0] s, x, d, dsv, input int per);
        chk("write count", 32'(n), 32'(mem_i.wlog_a.size()));
        for (int i = 0; i < n && i < mem_i.wlog_a.size(); i++) begin
            chk("write addr", d + 32'(i % per) * dsv, mem_i.wlog_a[i]);
            chk("write data", pat(s + 32'(i % per) * x), mem_i.wlog_d[i]);
        end
    endtask

    task automatic go(input dd_cfg_t c, input logic by_trig);
        mem_i.rlog.delete();
        mem_i.wlog_a.delete();
        mem_i.wlog_d.delete();
        nb = 0;
        nf = 0;
        @(posedge sys_clk);
        cfg     <= c;
        start   <= !by_trig;
        trig_in <= by_trig;
        @(posedge sys_clk);
        start   <= 1'b0;
        trig_in <= 1'b0;
        #1;
        chk("busy after start", 32'h1, 32'(busy));
    endtask

    // Halt goes out hold cycles into the run; a negative hold never halts
    task automatic finish(input int hold);
        for (int i = 0; i < 3000; i++) begin
            @(posedge sys_clk);
            halt <= (i == hold);
            #1;
            nb += 32'(buf_irq === 1'b1);
            nf += 32'(frac_irq === 1'b1);
            if (done_trig === 1'b1) break;
        end
        chk("done pulse", 32'h1, 32'(done_trig));
        repeat (2) @(posedge sys_clk);
        #1;
        chk("busy after done", 32'h0, 32'(busy));
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_linear;
        go(mk(FL_STOP, 2'h0, 32'h10, 32'sh4, 32'h200, 32'sh4, 32'h0, 16'h4), 1'b0);
        finish(-1);
        chk("unit irq", 32'h1, 32'(nb));
        chk_wr(4, 32'h10, 32'sh4, 32'h200, 32'sh4, 4);
        repeat (20) @(posedge sys_clk);
        #1;
        chk("no restart", 32'h4, 32'(mem_i.wlog_a.size()));
        chk("still idle", 32'h0, 32'(busy));
        $display("test linear done");
    endtask

    task automatic t_stride;
        mem_i.lat = 2;
        go(mk(FL_STOP, 2'h0, 32'h40, -32'sh4, 32'h280, 32'sh0, 32'h0, 16'h3), 1'b1);
        finish(-1);
        chk_wr(3, 32'h40, -32'sh4, 32'h280, 32'sh0, 3);
        mem_i.lat = 0;
        $display("test stride done");
    endtask

    task automatic t_auto(input logic [1:0] fr);
        int n;
        go(mk(FL_AUTO, fr, 32'h50, 32'sh4, 32'h220, 32'sh4, 32'h0, 16'h4), 1'b0);
        finish(150);
        n = mem_i.wlog_a.size();
        chk("whole units", 32'h0, 32'(n % 4));
        chk("several passes", 32'h1, 32'(n >= 8));
        chk("full irqs", 32'(n / 4), 32'(nb));
        chk("part irqs", 32'(n / 4 * ((fr == 2'h1) ? 2 : 4)), 32'(nf));
        chk_wr(n, 32'h50, 32'sh4, 32'h220, 32'sh4, 4);
        $display("test auto done");
    endtask

    task automatic t_linked;
        logic [31:0] ed [$];
        put(192, '{32'h310, 32'h20, 32'h2, 32'h1});
        put(196, '{32'h0, 32'h30, 32'h3, 32'h0});
        go(mk(FL_LIN, 2'h0, 32'h0, 32'sh4, 32'h200, 32'sh4, 32'h300, 16'h1), 1'b0);
        finish(-1);
        er = '{32'h300, 32'h304, 32'h308, 32'h30c, 32'h20, 32'h24,
               32'h310, 32'h314, 32'h318, 32'h31c, 32'h30, 32'h34, 32'h38};
        chk_q("read addr", er, mem_i.rlog);
        ed = '{pat(32'h20), pat(32'h24), pat(32'h30), pat(32'h34), pat(32'h38)};
        chk_q("write data", ed, mem_i.wlog_d);
        chk("unit irqs", 32'h2, 32'(nb));
        $display("test linked done");
    endtask

    task automatic t_desc(input dd_flow_t f, input logic [31:0] dsc, input int hold);
        go(mk(f, 2'h0, 32'h0, 32'sh4, 32'h200, 32'sh4, dsc, 16'h2), 1'b0);
        finish(hold);
        chk_q("read addr", er, mem_i.rlog);
        $display("test descriptor flow done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic conclude;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            conclude();
        end
    end

    initial begin
        for (int i = 0; i < 256; i++) mem_i.mem[i] = 32'h5a5a0000 + 32'(i);
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        t_linear();
        t_stride();
        t_auto(2'h1);
        t_auto(2'h2);
        t_linked();
        put(208, '{32'h348, 32'h60, 32'h340, 32'h70});
        er = '{32'h340, 32'h344, 32'h60, 32'h64, 32'h348, 32'h34c, 32'h70, 32'h74, 32'h340};
        t_desc(FL_PP, 32'h340, 120);
        put(224, '{32'h60, 32'h70});
        er = '{32'h380, 32'h60, 32'h64, 32'h384, 32'h70, 32'h74};
        t_desc(FL_ARR, 32'h380, 80);
        // Two rows of two: the row stride differs from the element stride
        put(232, '{32'h0, 32'h60, 32'h20002, 32'h4, 32'h8, 32'h0});
        er = '{32'h3a0, 32'h3a4, 32'h3a8, 32'h3ac, 32'h3b0, 32'h3b4,
               32'h60, 32'h64, 32'h6c, 32'h70};
        t_desc(FL_2D, 32'h3a0, -1);
        conclude();
    end
endmodule // tb_descriptor_dma_controller
`default_nettype wire
